/* core/updown_counter_4bit.sv */
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps

// How it works
// - four-bit state, wraps 15 to 0 and back
// - all changes except master clear on rising edge
// - priority: async clear, sync clear, load, count, hold
// - async clear low zeroes state at once
// - sync clear zeroes state at next edge
// - load copies load_value at next edge
// - count only with both enables low, else hold
// - direction high counts up, low counts down
// - terminal count combinational from trickle, state, direction
// - terminal count stays until state or inputs change
// - clocked carry low in clock low phase only
// - output enable gates the count outputs only (via count_out_oe_o), never the counting
module updown_counter_4bit (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic async_clear_n_i,
    input wire logic sync_clear_n_i,
    input wire logic load_n_i,
    input wire logic count_enable_parallel_n_i,
    input wire logic count_enable_trickle_n_i,
    input wire logic count_up_i,
    input wire logic output_enable_n_i,
    input wire logic [updown_counter_pkg::CNT_W-1:0] load_value_i,
    output logic [updown_counter_pkg::CNT_W-1:0] count_out_o,
    output logic count_out_oe_o,
    output logic terminal_count_n_o,
    output logic clocked_carry_n_o,
    input wire logic [updown_counter_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [updown_counter_pkg::BE_W-1:0] avs_byteenable_i,
    input wire logic [updown_counter_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [updown_counter_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // resets
    // ------------------------------------------------------------
    logic rst_n_w;
    logic clr_n_w;
    logic cnt_rst_n_w;

    reset_release_sync u_sys_rst (
        .clk_i(clk_sys_i),
        .arst_n_i(nrst_i),
        .rst_n_o(rst_n_w)
    );

    // clear asserts without the clock, releases on it so no edge sees a half release
    reset_release_sync u_clr_rst (
        .clk_i(clk_sys_i),
        .arst_n_i(async_clear_n_i),
        .rst_n_o(clr_n_w)
    );

    assign cnt_rst_n_w = rst_n_w & clr_n_w;

    // ------------------------------------------------------------
    // mode select
    // ------------------------------------------------------------
    updown_counter_pkg::ctrl_t ctrl_w;
    updown_counter_pkg::mode_t mode_w;
    logic [updown_counter_pkg::CNT_W-1:0] count_ff;
    logic [updown_counter_pkg::CNT_W-1:0] nxt_count;
    logic enables_low_w;
    logic term_w;
    logic carry_cond_w;

    assign ctrl_w = '{
        sync_clear_n: sync_clear_n_i,
        load_n: load_n_i,
        count_enable_parallel_n: count_enable_parallel_n_i,
        count_enable_trickle_n: count_enable_trickle_n_i,
        count_up: count_up_i
    };

    assign enables_low_w = !ctrl_w.count_enable_parallel_n && !ctrl_w.count_enable_trickle_n;

    assign mode_w = !ctrl_w.sync_clear_n ? updown_counter_pkg::MODE_SCLR :
                    !ctrl_w.load_n ? updown_counter_pkg::MODE_LOAD :
                    !enables_low_w ? updown_counter_pkg::MODE_HOLD :
                    ctrl_w.count_up ? updown_counter_pkg::MODE_UP :
                    updown_counter_pkg::MODE_DOWN;

    always_comb begin
        case (mode_w)
            updown_counter_pkg::MODE_SCLR: nxt_count = updown_counter_pkg::CNT_ZERO;
            updown_counter_pkg::MODE_LOAD: nxt_count = load_value_i;
            updown_counter_pkg::MODE_UP: nxt_count = count_ff + updown_counter_pkg::CNT_STEP;
            updown_counter_pkg::MODE_DOWN: nxt_count = count_ff - updown_counter_pkg::CNT_STEP;
            updown_counter_pkg::MODE_HOLD: nxt_count = count_ff;
            default: nxt_count = count_ff;
        endcase
    end

    // ------------------------------------------------------------
    // counter state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge cnt_rst_n_w) begin
        if (!cnt_rst_n_w) begin
            count_ff <= updown_counter_pkg::CNT_ZERO;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // decode is left combinational so a cascade on this clock sees it in the same cycle;
    // it may spike, which is why the clocked carry exists
    assign term_w = !ctrl_w.count_enable_trickle_n &&
                    ((ctrl_w.count_up && count_ff == updown_counter_pkg::CNT_MAX) ||
                     (!ctrl_w.count_up && count_ff == updown_counter_pkg::CNT_ZERO));
    assign terminal_count_n_o = !term_w;

    assign carry_cond_w = clr_n_w && ctrl_w.sync_clear_n && ctrl_w.load_n && enables_low_w &&
                          term_w;
    assign clocked_carry_n_o = !(carry_cond_w && !clk_sys_i);

    assign count_out_o = count_ff;
    assign count_out_oe_o = !output_enable_n_i;

    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    logic term_prev_ff;
    logic [updown_counter_pkg::IRQ_W-1:0] event_w;
    logic counting_w;

    assign counting_w = (mode_w == updown_counter_pkg::MODE_UP) ||
                        (mode_w == updown_counter_pkg::MODE_DOWN);
    assign event_w[updown_counter_pkg::IRQ_TERM_BIT] = clr_n_w && term_w && !term_prev_ff;
    assign event_w[updown_counter_pkg::IRQ_WRAP_BIT] = clr_n_w && counting_w && term_w;
    assign event_w[updown_counter_pkg::IRQ_LOAD_BIT] = clr_n_w &&
                                                       (mode_w == updown_counter_pkg::MODE_LOAD);
    assign event_w[updown_counter_pkg::IRQ_SCLR_BIT] = clr_n_w &&
                                                       (mode_w == updown_counter_pkg::MODE_SCLR);

    always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
        if (!rst_n_w) begin
            term_prev_ff <= 1'h0;
        end else begin
            term_prev_ff <= term_w;
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    updown_counter_pkg::bus_req_t req_w;
    updown_counter_pkg::bus_state_t bus_state_ff;
    updown_counter_pkg::bus_state_t nxt_bus_state;
    updown_counter_pkg::status_t status_w;
    logic [updown_counter_pkg::DATA_W-1:0] readdata_ff;
    logic [updown_counter_pkg::DATA_W-1:0] rdata_w;
    logic wait_ff;
    logic commit_wr_w;
    logic lane_w;
    logic wr_clear_w;
    logic wr_enable_w;

    assign req_w = '{
        read: avs_read_i,
        write: avs_write_i,
        address: avs_address_i,
        byteenable: avs_byteenable_i,
        writedata: avs_writedata_i
    };

    assign nxt_bus_state = (bus_state_ff == updown_counter_pkg::BUS_IDLE) &&
                           (req_w.read || req_w.write) ?
                           updown_counter_pkg::BUS_ACK : updown_counter_pkg::BUS_IDLE;
    assign commit_wr_w = (bus_state_ff == updown_counter_pkg::BUS_ACK) && req_w.write;
    assign lane_w = req_w.byteenable[updown_counter_pkg::IRQ_LANE];
    assign wr_clear_w = commit_wr_w && lane_w &&
                        (req_w.address == updown_counter_pkg::REG_IRQ_CLEAR_OFS);
    assign wr_enable_w = commit_wr_w && lane_w &&
                         (req_w.address == updown_counter_pkg::REG_IRQ_ENABLE_OFS);

    // ------------------------------------------------------------
    // interrupt registers
    // ------------------------------------------------------------
    logic [updown_counter_pkg::IRQ_W-1:0] irq_status_ff;
    logic [updown_counter_pkg::IRQ_W-1:0] irq_en_ff;
    logic [updown_counter_pkg::IRQ_W-1:0] nxt_irq_status;
    logic [updown_counter_pkg::IRQ_W-1:0] nxt_irq_en;
    logic [updown_counter_pkg::IRQ_W-1:0] clear_mask_w;
    logic irq_ff;

    assign clear_mask_w = wr_clear_w ? req_w.writedata[updown_counter_pkg::IRQ_W-1:0] :
                          updown_counter_pkg::IRQ_NONE;
    // a new event outranks a clear landing in the same cycle
    assign nxt_irq_status = (irq_status_ff & ~clear_mask_w) | event_w;
    assign nxt_irq_en = wr_enable_w ? req_w.writedata[updown_counter_pkg::IRQ_W-1:0] : irq_en_ff;

    assign status_w = '{
        rsvd: '0,
        outputs_on: !output_enable_n_i,
        clocked_carry: carry_cond_w,
        count_up: ctrl_w.count_up,
        terminal_count: term_w,
        spare: 1'h0,
        count: count_ff
    };

    assign rdata_w = !req_w.read ? updown_counter_pkg::RDATA_NONE :
                     (req_w.address == updown_counter_pkg::REG_STATUS_OFS) ? status_w :
                     (req_w.address == updown_counter_pkg::REG_IRQ_STATUS_OFS) ?
                     {{(updown_counter_pkg::DATA_W-updown_counter_pkg::IRQ_W){1'h0}},
                      irq_status_ff} :
                     (req_w.address == updown_counter_pkg::REG_IRQ_ENABLE_OFS) ?
                     {{(updown_counter_pkg::DATA_W-updown_counter_pkg::IRQ_W){1'h0}},
                      irq_en_ff} :
                     updown_counter_pkg::RDATA_NONE;

    always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
        if (!rst_n_w) begin
            bus_state_ff <= updown_counter_pkg::BUS_IDLE;
            wait_ff <= 1'h1;
            readdata_ff <= updown_counter_pkg::RDATA_NONE;
        end else begin
            bus_state_ff <= nxt_bus_state;
            wait_ff <= (nxt_bus_state != updown_counter_pkg::BUS_ACK);
            readdata_ff <= rdata_w;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_w) begin
        if (!rst_n_w) begin
            irq_status_ff <= updown_counter_pkg::IRQ_NONE;
            irq_en_ff <= updown_counter_pkg::IRQ_EN_RST;
            irq_ff <= 1'h0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_en_ff <= nxt_irq_en;
            irq_ff <= |(nxt_irq_status & nxt_irq_en);
        end
    end

    assign avs_readdata_o = readdata_ff;
    assign avs_waitrequest_o = wait_ff;
    assign irq_o = irq_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_w);

    sequence s_free;
        clr_n_w && sync_clear_n_i && load_n_i;
    endsequence

    sequence s_count_dir(logic dir, logic [3:0] at);
        s_free ##0 (enables_low_w && count_up_i == dir && count_ff == at);
    endsequence

    property p_wrap_up;
        disable iff (!cnt_rst_n_w)
        s_count_dir(1'h1, updown_counter_pkg::CNT_MAX) |=> count_ff == 4'h0;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("no wrap from 15 to 0");

    property p_wrap_down;
        disable iff (!cnt_rst_n_w)
        s_count_dir(1'h0, updown_counter_pkg::CNT_ZERO) |=> count_ff == 4'hF;
    endproperty
    a_wrap_down: assert property (p_wrap_down) else $error("no wrap from 0 to 15");

    property p_async_clear;
        !async_clear_n_i |-> count_ff == 4'h0 && count_out_o == 4'h0;
    endproperty
    a_async_clear: assert property (p_async_clear) else $error("async clear not held");

    property p_sync_clear;
        disable iff (!cnt_rst_n_w)
        (clr_n_w && !sync_clear_n_i && !load_n_i) |=> count_ff == 4'h0;
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("sync clear lost to load");

    property p_load;
        disable iff (!cnt_rst_n_w)
        (clr_n_w && sync_clear_n_i && !load_n_i) |=> count_ff == $past(load_value_i);
    endproperty
    a_load: assert property (p_load) else $error("load value not taken");

    property p_hold;
        disable iff (!cnt_rst_n_w)
        s_free ##0 !enables_low_w |=> $stable(count_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while disabled");

    property p_count;
        disable iff (!cnt_rst_n_w)
        s_free ##0 enables_low_w ##1 1'h1 |->
            count_ff == ($past(count_up_i) ? 4'(($past(count_ff) + 4'h1)) :
                                             4'(($past(count_ff) - 4'h1)));
    endproperty
    a_count: assert property (p_count) else $error("wrong count step");

    property p_term_hold;
        !terminal_count_n_o ##1 ($stable(count_ff) && $stable(count_up_i) &&
                                 $stable(count_enable_trickle_n_i)) |-> !terminal_count_n_o;
    endproperty
    a_term_hold: assert property (p_term_hold) else $error("terminal count dropped early");

    property p_term_trickle;
        count_enable_trickle_n_i |-> terminal_count_n_o;
    endproperty
    a_term_trickle: assert property (p_term_trickle) else $error("terminal count without trickle");

    // sampled just before the rising edge, i.e. at the end of the low phase
    property p_carry_low;
        clocked_carry_n_o == !(sync_clear_n_i && load_n_i && clr_n_w &&
                               !count_enable_parallel_n_i && !count_enable_trickle_n_i &&
                               count_ff == (count_up_i ? updown_counter_pkg::CNT_MAX :
                                                         updown_counter_pkg::CNT_ZERO));
    endproperty
    a_carry_low: assert property (p_carry_low) else $error("clocked carry wrong in low phase");

    property p_carry_high;
        @(negedge clk_sys_i) clocked_carry_n_o;
    endproperty
    a_carry_high: assert property (p_carry_high) else $error("clocked carry low in high phase");

    property p_oe;
        output_enable_n_i |-> !count_out_oe_o && count_out_o == count_ff;
    endproperty
    a_oe: assert property (p_oe) else $error("outputs driven while disabled");

endmodule : updown_counter_4bit

/* core/updown_counter_pkg.sv */
package updown_counter_pkg;

    // ------------------------------------------------------------
    // counter geometry
    // ------------------------------------------------------------
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
    localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE_OFS = 4'hC;
    localparam logic [DATA_W-1:0] RDATA_NONE = 32'h0;

    // ------------------------------------------------------------
    // interrupt layout, shared by status, clear and enable
    // ------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_TERM_BIT = 0;
    localparam int IRQ_WRAP_BIT = 1;
    localparam int IRQ_LOAD_BIT = 2;
    localparam int IRQ_SCLR_BIT = 3;
    localparam int IRQ_LANE = 0;
    localparam logic [IRQ_W-1:0] IRQ_NONE = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_HOLD = 3'h0,
        MODE_UP = 3'h1,
        MODE_DOWN = 3'h3,
        MODE_LOAD = 3'h2,
        MODE_SCLR = 3'h6
    } mode_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ACK = 1'h1
    } bus_state_t;

    typedef struct packed {
        logic sync_clear_n;
        logic load_n;
        logic count_enable_parallel_n;
        logic count_enable_trickle_n;
        logic count_up;
    } ctrl_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [BE_W-1:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } bus_req_t;

    typedef struct packed {
        logic [22:0] rsvd;
        logic outputs_on;
        logic clocked_carry;
        logic count_up;
        logic terminal_count;
        logic spare;
        logic [CNT_W-1:0] count;
    } status_t;

endpackage : updown_counter_pkg

/* core/reset_release_sync.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------
// asynchronous assert, two-stage synchronous release
// ------------------------------------------------------------
module reset_release_sync (
    input wire logic clk_i,
    input wire logic arst_n_i,
    output logic rst_n_o
);

    logic [1:0] stage_ff;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage_ff <= 2'h0;
        end else begin
            stage_ff <= {stage_ff[0], 1'h1};
        end
    end

    assign rst_n_o = stage_ff[1];

endmodule : reset_release_sync

/* verification/cascade_stage_model.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------
// next counter stage of a lookahead cascade
// ------------------------------------------------------------
module cascade_stage_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic carry_in_n_i,
    input wire logic enable_parallel_n_i,
    input wire logic clocked_carry_n_i,
    output logic [3:0] upper_count_o,
    output logic [7:0] carry_pulses_o
);
    // lower stage terminal count feeds this stage's enable
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            upper_count_o <= 4'h0;
        end else if (!carry_in_n_i && !enable_parallel_n_i) begin
            upper_count_o <= upper_count_o + 4'h1;
        end
    end

    // clocked carry used as a clock; terminal count may spike, so never this way
    always_ff @(posedge clocked_carry_n_i or negedge nrst_i) begin
        if (!nrst_i) begin
            carry_pulses_o <= 8'h00;
        end else begin
            carry_pulses_o <= carry_pulses_o + 8'h01;
        end
    end
endmodule : cascade_stage_model

/* verification/tb.sv */
`timescale 1ns/10ps

module tb;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic aclr_n = 1'h1;
    logic sclr_n = 1'h1;
    logic ld_n = 1'h1;
    logic en_par_n = 1'h1;
    logic en_tr_n = 1'h1;
    logic up = 1'h1;
    logic oe_n = 1'h0;
    logic [3:0] ld_val = 4'h0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] cnt;
    logic cnt_oe;
    logic term_n;
    logic carry_n;
    logic [31:0] rdata;
    logic wait_req;
    logic irq;
    logic [3:0] upper;
    logic [7:0] pulses;
    logic [3:0] upper0;
    logic [7:0] pulses0;
    logic [31:0] q;
    int mismatches = 0;
    int num_checks = 0;

    initial begin
        forever #20 clk = ~clk;
    end

    updown_counter_4bit dut_u (.clk_sys_i(clk), .nrst_i(nrst), .async_clear_n_i(aclr_n),
        .sync_clear_n_i(sclr_n), .load_n_i(ld_n), .count_enable_parallel_n_i(en_par_n),
        .count_enable_trickle_n_i(en_tr_n), .count_up_i(up), .output_enable_n_i(oe_n),
        .load_value_i(ld_val), .count_out_o(cnt), .count_out_oe_o(cnt_oe),
        .terminal_count_n_o(term_n), .clocked_carry_n_o(carry_n), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .irq_o(irq));

    cascade_stage_model stage_u (.clk_sys_i(clk), .nrst_i(nrst), .carry_in_n_i(term_n),
        .enable_parallel_n_i(en_par_n), .clocked_carry_n_i(carry_n),
        .upper_count_o(upper), .carry_pulses_o(pulses));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_v

    task automatic chk_b(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_b

    task automatic tick();
        @(posedge clk);
    endtask : tick

    // outputs looked at in the clock low phase, after combinational settling
    task automatic settle();
        @(negedge clk);
        #1;
    endtask : settle

    // waitrequest is read before this edge's updates land, i.e. as sampled
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        tick();
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            tick();
            n++;
        end while (wait_req !== 1'h0 && n < 20);
        q = rdata;
        wr <= 1'h0;
        rd <= 1'h0;
        if (n >= 20) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, wait_req, 1'h0);
        end
    endtask : bus

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        bus(1'b0, updown_counter_pkg::REG_IRQ_ENABLE_OFS, 32'h0);
        chk_v(q, 32'h0);
        bus(1'b0, updown_counter_pkg::REG_IRQ_CLEAR_OFS, 32'h0);
        chk_v(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk_v(q, 32'h0);
    endtask : t_regs

    task automatic t_wrap();
        tick();
        ld_val <= 4'hE;
        ld_n <= 1'h0;
        tick();
        ld_n <= 1'h1;
        en_par_n <= 1'h0;
        en_tr_n <= 1'h0;
        settle();
        chk_v({28'h0, cnt}, 32'hE);
        chk_b(term_n, 1'h1);
        tick();
        settle();
        chk_v({28'h0, cnt}, 32'hF);
        chk_b(term_n, 1'h0);
        chk_b(carry_n, 1'h0);
        tick();
        up <= 1'h0;
        settle();
        chk_v({28'h0, cnt}, 32'h0);
        chk_b(term_n, 1'h0);
        tick();
        en_par_n <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'hF);
        chk_b(term_n, 1'h1);
    endtask : t_wrap

    task automatic t_hold();
        tick();
        up <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'hF);
        chk_b(term_n, 1'h0);
        chk_b(carry_n, 1'h1);
        tick();
        en_tr_n <= 1'h1;
        settle();
        chk_b(term_n, 1'h1);
        tick();
        en_par_n <= 1'h0;
        tick();
        en_par_n <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'hF);
    endtask : t_hold

    task automatic t_prio();
        tick();
        sclr_n <= 1'h0;
        ld_n <= 1'h0;
        ld_val <= 4'h5;
        en_par_n <= 1'h0;
        en_tr_n <= 1'h0;
        tick();
        sclr_n <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'h0);
        tick();
        ld_n <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'h5);
        tick();
        en_par_n <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'h6);
    endtask : t_prio

    task automatic t_async();
        tick();
        aclr_n <= 1'h0;
        ld_n <= 1'h0;
        ld_val <= 4'h9;
        #5;
        chk_v({28'h0, cnt}, 32'h0);
        tick();
        aclr_n <= 1'h1;
        ld_n <= 1'h1;
        en_par_n <= 1'h0;
        oe_n <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'h0);
        chk_b(cnt_oe, 1'h0);
        repeat (2) begin
            tick();
            settle();
            chk_v({28'h0, cnt}, 32'h0);
        end
        tick();
        oe_n <= 1'h0;
        en_par_n <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'h1);
        chk_b(cnt_oe, 1'h1);
    endtask : t_async

    task automatic t_cascade();
        tick();
        ld_val <= 4'h0;
        ld_n <= 1'h0;
        upper0 = upper;
        pulses0 = pulses;
        tick();
        ld_n <= 1'h1;
        en_par_n <= 1'h0;
        repeat (31) tick();
        tick();
        en_par_n <= 1'h1;
        settle();
        chk_v({28'h0, cnt}, 32'h0);
        chk_v({28'h0, 4'(upper - upper0)}, 32'h2);
        chk_v({24'h0, 8'(pulses - pulses0)}, 32'h2);
    endtask : t_cascade

    task automatic t_irq();
        bus(1'b1, updown_counter_pkg::REG_IRQ_CLEAR_OFS, 32'hF);
        bus(1'b0, updown_counter_pkg::REG_IRQ_STATUS_OFS, 32'h0);
        chk_v(q, 32'h0);
        bus(1'b1, updown_counter_pkg::REG_IRQ_ENABLE_OFS, 32'h1);
        bus(1'b0, updown_counter_pkg::REG_IRQ_ENABLE_OFS, 32'h0);
        chk_v(q, 32'h1);
        chk_b(irq, 1'h0);
        tick();
        ld_val <= 4'hE;
        ld_n <= 1'h0;
        tick();
        ld_n <= 1'h1;
        en_par_n <= 1'h0;
        tick();
        en_par_n <= 1'h1;
        repeat (2) tick();
        settle();
        chk_b(irq, 1'h1);
        bus(1'h1, updown_counter_pkg::REG_IRQ_STATUS_OFS, 32'h0);
        bus(1'h0, updown_counter_pkg::REG_IRQ_STATUS_OFS, 32'h0);
        chk_v(q, 32'h5);
        bus(1'h0, updown_counter_pkg::REG_STATUS_OFS, 32'h0);
        chk_v(q, 32'h0000016F);
        bus(1'h1, updown_counter_pkg::REG_IRQ_ENABLE_OFS, 32'h0);
        repeat (2) tick();
        settle();
        chk_b(irq, 1'h0);
        bus(1'h1, updown_counter_pkg::REG_IRQ_ENABLE_OFS, 32'h4);
        repeat (2) tick();
        settle();
        chk_b(irq, 1'h1);
        bus(1'h1, updown_counter_pkg::REG_IRQ_CLEAR_OFS, 32'h5);
        repeat (2) tick();
        settle();
        chk_b(irq, 1'h0);
        bus(1'h0, updown_counter_pkg::REG_IRQ_STATUS_OFS, 32'h0);
        chk_v(q, 32'h0);
    endtask : t_irq

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (7) tick();
        settle();
        chk_v({28'h0, cnt}, 32'h0);
        chk_b(wait_req, 1'h1);
        chk_b(irq, 1'h0);
        tick();
        nrst <= 1'h1;
        repeat (2) tick();
        t_regs();
        t_wrap();
        t_hold();
        t_prio();
        t_async();
        t_cascade();
        t_irq();
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
        end_sim();
    end
endmodule : tb
